/* pkg/cdd_cfg.svh */
// Purpose: constants of the chaining descriptor DMA link and registers
// Assumes: included by package, interface and both ends
// Notes: register offsets are dword indices inside a 256-byte window
`ifndef CDD_CFG_SVH
`define CDD_CFG_SVH
`define CDD_DW 32
`define CDD_LEN_W 16
`define CDD_TAG_W 2
// 64 dwords of register space, i.e. a 256-byte window
`define CDD_REG_IDX_W 6
// each channel block spans four dwords
`define CDD_CHAN_IDX_W 2
`define CDD_BLK_W 4
`define CDD_REG_CTRL 2'h0
`define CDD_REG_TAB_HI 2'h1
`define CDD_REG_TAB_LO 2'h2
`define CDD_REG_STAT 2'h3
`define CDD_WR_BLOCK 4'h0
`define CDD_RD_BLOCK 4'h1
`define CDD_CTRL_CNT_W 16
`define CDD_CTRL_MSI_BIT 16
`define CDD_DESC_NOTIFY_BIT 16
`define CDD_DESC_DWORDS 16'h0004
`define CDD_DESC_BYTES 32'h0000_0010
`define CDD_STAT_BUSY_BIT 31
`define CDD_TAG_RD_DESC 2'h0
`define CDD_TAG_WR_DESC 2'h1
`define CDD_TAG_RD_DATA 2'h2
`define CDD_TAG_WR_DATA 2'h3
`define CDD_MSI_VEC_WR 1'h0
`define CDD_MSI_VEC_RD 1'h1
`define CDD_REG_RST 32'h0000_0000
`endif

/* pkg/cdd_pkg.sv */
// Purpose: types shared by both ends of the DMA link
// Assumes: cdd_cfg.svh holds the numbers
// Notes: none
`include "cdd_cfg.svh"
package cdd_pkg;
  typedef enum logic [1:0] {CDD_TX_MRD, CDD_TX_MWR, CDD_TX_CPL} cdd_tx_kind_t;
  typedef enum logic [1:0] {CDD_RX_CPL, CDD_RX_REGWR, CDD_RX_REGRD}
    cdd_rx_kind_t;
  typedef struct packed {
    cdd_rx_kind_t kind;
    logic [`CDD_TAG_W-1:0] tag;
    logic [`CDD_DW-1:0] addr;
    logic [`CDD_DW-1:0] data;
  } cdd_rx_t;
endpackage

/* pkg/cdd_link_if.sv */
// Purpose: transaction link between the DMA endpoint and the host side
// Assumes: one packet per beat on each direction, valid/ready handshake
// Notes: no digest field exists, packets carry no end-to-end crc
`timescale 1ns/10ps
`include "cdd_cfg.svh"
interface cdd_link_if;
  import cdd_pkg::*;
  logic tx_valid;
  logic tx_ready;
  cdd_tx_kind_t tx_kind;
  logic [`CDD_TAG_W-1:0] tx_tag;
  logic [`CDD_DW-1:0] tx_addr;
  logic [`CDD_LEN_W-1:0] tx_len;
  logic [`CDD_DW-1:0] tx_data;
  logic rx_valid;
  logic rx_ready;
  cdd_rx_kind_t rx_kind;
  logic [`CDD_TAG_W-1:0] rx_tag;
  logic [`CDD_DW-1:0] rx_addr;
  logic [`CDD_DW-1:0] rx_data;
  logic msi_valid;
  logic msi_ready;
  logic msi_vec;
  modport dev(output tx_valid, tx_kind, tx_tag, tx_addr, tx_len, tx_data,
    input tx_ready, input rx_valid, rx_kind, rx_tag, rx_addr, rx_data,
    output rx_ready, output msi_valid, msi_vec, input msi_ready);
  modport host(input tx_valid, tx_kind, tx_tag, tx_addr, tx_len, tx_data,
    output tx_ready, output rx_valid, rx_kind, rx_tag, rx_addr, rx_data,
    input rx_ready, input msi_valid, msi_vec, output msi_ready);
endinterface // cdd_link_if

/* logic/cdd_dev.sv */
// Purpose: chaining descriptor DMA engine, endpoint end of the link
// Assumes: host answers each read request with in-order completions
// Notes: one read and one write channel, local memory inside
`timescale 1ns/10ps
`include "cdd_cfg.svh"

// ********************
// two-entry receive buffer
// ********************
module cdd_fifo2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] slot [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = slot[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= !wr_ptr;
      end
      if (pop) begin
        rd_ptr <= !rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // cdd_fifo2

// ********************
// one DMA channel
// ********************
module cdd_chan #(
  parameter bit IS_READ = 1'b1,
  parameter logic [`CDD_TAG_W-1:0] TAG_DESC = `CDD_TAG_RD_DESC,
  parameter logic [`CDD_TAG_W-1:0] TAG_DATA = `CDD_TAG_RD_DATA,
  parameter int MEM_AW = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic prog_we,
  input wire logic [`CDD_CHAN_IDX_W-1:0] prog_idx,
  input wire logic [`CDD_DW-1:0] prog_wdata,
  output logic [`CDD_DW-1:0] prog_rdata,
  output logic busy,
  output logic req_valid,
  output cdd_pkg::cdd_tx_kind_t req_kind,
  output logic [`CDD_DW-1:0] req_addr,
  output logic [`CDD_LEN_W-1:0] req_len,
  output logic [`CDD_TAG_W-1:0] req_tag,
  output logic [`CDD_DW-1:0] req_data,
  input wire logic grant,
  input wire logic cpl_valid,
  input wire logic [`CDD_TAG_W-1:0] cpl_tag,
  input wire logic [`CDD_DW-1:0] cpl_data,
  output logic mem_we,
  output logic [MEM_AW-1:0] mem_addr,
  output logic [`CDD_DW-1:0] mem_wdata,
  input wire logic [`CDD_DW-1:0] mem_rdata,
  output logic msi_req,
  input wire logic msi_ack
);
  import cdd_pkg::*;
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_DESC, ST_REQ, ST_DATA,
    ST_NOTIFY} cdd_chan_st_t;
  cdd_chan_st_t st;
  logic [`CDD_DW-1:0] ctrl;
  logic [`CDD_DW-1:0] tab_hi;
  logic [`CDD_DW-1:0] tab_lo;
  logic [`CDD_DW-1:0] desc [0:3];
  logic [`CDD_DW-1:0] desc_addr;
  logic [`CDD_LEN_W-1:0] desc_left;
  logic [`CDD_LEN_W-1:0] done_cnt;
  logic [`CDD_LEN_W-1:0] word_cnt;
  logic [`CDD_LEN_W-1:0] d_len;
  logic d_notify;
  logic last_word;
  logic hit_desc;
  logic hit_data;
  logic start;
  logic xfer_end;
  logic [MEM_AW-1:0] base_idx;

  assign d_len = desc[0][`CDD_LEN_W-1:0];
  assign d_notify = desc[0][`CDD_DESC_NOTIFY_BIT];
  assign last_word = (word_cnt == d_len - 16'h1);
  assign hit_desc = cpl_valid && (cpl_tag == TAG_DESC) && (st == ST_DESC);
  assign hit_data = cpl_valid && (cpl_tag == TAG_DATA) && (st == ST_DATA);
  // writing the control word starts a chain; addresses go in first
  assign start = prog_we && (prog_idx == `CDD_REG_CTRL) && (st == ST_IDLE)
    && (prog_wdata[`CDD_CTRL_CNT_W-1:0] != 16'h0);
  assign xfer_end = (IS_READ ? (hit_data && last_word)
    : (st == ST_REQ && grant && last_word));
  assign busy = (st != ST_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `CDD_REG_RST;
      tab_hi <= `CDD_REG_RST;
      tab_lo <= `CDD_REG_RST;
    end else if (prog_we) begin
      case (prog_idx)
        `CDD_REG_CTRL: ctrl <= prog_wdata;
        `CDD_REG_TAB_HI: tab_hi <= prog_wdata;
        `CDD_REG_TAB_LO: tab_lo <= prog_wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (prog_idx)
      `CDD_REG_CTRL: prog_rdata = ctrl;
      `CDD_REG_TAB_HI: prog_rdata = tab_hi;
      `CDD_REG_TAB_LO: prog_rdata = tab_lo;
      default: prog_rdata = {busy, 15'h0, done_cnt};
    endcase
  end

  // sequencing: fetch, then move the block, then notify if the descriptor and ctrl both ask for it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= ST_IDLE;
      word_cnt <= 16'h0;
    end else begin
      case (st)
        ST_IDLE: if (start) begin
          st <= ST_FETCH;
        end
        ST_FETCH: if (grant) begin
          st <= ST_DESC;
          word_cnt <= 16'h0;
        end
        ST_DESC: if (hit_desc) begin
          word_cnt <= word_cnt + 16'h1;
          if (word_cnt == `CDD_DESC_DWORDS - 16'h1) begin
            st <= ST_REQ;
            word_cnt <= 16'h0;
          end
        end
        ST_REQ: if (grant) begin
          if (IS_READ) begin
            st <= ST_DATA;
          end else begin
            word_cnt <= word_cnt + 16'h1;
          end
        end
        ST_DATA: if (hit_data) begin
          word_cnt <= word_cnt + 16'h1;
        end
        ST_NOTIFY: if (msi_ack) begin
          st <= (desc_left == 16'h0) ? ST_IDLE : ST_FETCH;
        end
        default: st <= ST_IDLE;
      endcase
      if (xfer_end) begin
        if (d_notify && ctrl[`CDD_CTRL_MSI_BIT]) begin
          st <= ST_NOTIFY;
        end else begin
          st <= (desc_left == 16'h1) ? ST_IDLE : ST_FETCH;
        end
      end
    end
  end

  // current descriptor, four dwords per table entry
  always_ff @(posedge clk) begin
    if (hit_desc) begin
      desc[word_cnt[1:0]] <= cpl_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      desc_addr <= `CDD_REG_RST;
      desc_left <= 16'h0;
      done_cnt <= 16'h0;
    end else if (start) begin
      desc_addr <= tab_lo;
      desc_left <= prog_wdata[`CDD_CTRL_CNT_W-1:0];
      done_cnt <= 16'h0;
    end else if (xfer_end) begin
      desc_addr <= desc_addr + `CDD_DESC_BYTES;
      desc_left <= desc_left - 16'h1;
      done_cnt <= done_cnt + 16'h1;
    end
  end

  // dword-aligned only: low two address bits are dropped
  assign base_idx = IS_READ ? desc[2][MEM_AW+1:2] : desc[1][MEM_AW+1:2];
  assign mem_addr = base_idx + word_cnt[MEM_AW-1:0];
  assign mem_we = hit_data;
  assign mem_wdata = cpl_data;
  assign msi_req = (st == ST_NOTIFY);

  always_comb begin
    req_valid = (st == ST_FETCH) || (st == ST_REQ);
    req_data = mem_rdata;
    if (st == ST_FETCH) begin
      req_kind = CDD_TX_MRD;
      req_addr = desc_addr;
      req_len = `CDD_DESC_DWORDS;
      req_tag = TAG_DESC;
    end else if (IS_READ) begin
      req_kind = CDD_TX_MRD;
      req_addr = desc[1];
      req_len = d_len;
      req_tag = TAG_DATA;
    end else begin
      req_kind = CDD_TX_MWR;
      req_addr = desc[2] + {word_cnt, 2'b00};
      req_len = 16'h1;
      req_tag = TAG_DATA;
    end
  end
endmodule // cdd_chan

// ********************
// Function
// ********************
module cdd_dev #(
  parameter int MEM_AW = 10
) (
  input wire logic clk,
  input wire logic rst,
  cdd_link_if.dev link,
  input wire logic [MEM_AW-1:0] usr_addr,
  input wire logic usr_we,
  input wire logic [`CDD_DW-1:0] usr_wdata,
  output logic [`CDD_DW-1:0] usr_rdata,
  output logic rd_busy,
  output logic wr_busy
);
  import cdd_pkg::*;
  logic [`CDD_DW-1:0] mem [0:(1<<MEM_AW)-1];
  cdd_rx_t rx_in;
  cdd_rx_t rx_out;
  logic rx_out_valid;
  logic rx_out_ready;
  logic pop;
  logic [`CDD_BLK_W-1:0] blk;
  logic [`CDD_CHAN_IDX_W-1:0] idx;
  logic rd_prog_we;
  logic wr_prog_we;
  logic [`CDD_DW-1:0] rd_prdata;
  logic [`CDD_DW-1:0] wr_prdata;
  logic cpl_pend;
  logic [`CDD_DW-1:0] cpl_data;
  logic [`CDD_TAG_W-1:0] cpl_tag;
  logic free;
  logic last_wr;
  logic g_cpl;
  logic g_rd;
  logic g_wr;
  logic rd_req;
  logic wr_req;
  cdd_tx_kind_t rd_kind;
  cdd_tx_kind_t wr_kind;
  logic [`CDD_DW-1:0] rd_addr;
  logic [`CDD_DW-1:0] wr_addr;
  logic [`CDD_LEN_W-1:0] rd_len;
  logic [`CDD_LEN_W-1:0] wr_len;
  logic [`CDD_TAG_W-1:0] rd_tag;
  logic [`CDD_TAG_W-1:0] wr_tag;
  logic [`CDD_DW-1:0] rd_data;
  logic [`CDD_DW-1:0] wr_data;
  logic rd_mem_we;
  logic [MEM_AW-1:0] rd_mem_addr;
  logic [`CDD_DW-1:0] rd_mem_wdata;
  logic [MEM_AW-1:0] wr_mem_addr;
  logic rd_msi;
  logic wr_msi;

  // ********************
  // receive path and register decode
  // ********************
  assign rx_in = {link.rx_kind, link.rx_tag, link.rx_addr, link.rx_data};

  cdd_fifo2 #(.W($bits(cdd_rx_t))) u_rxbuf (
    .clk(clk),
    .rst(rst),
    .in_valid(link.rx_valid),
    .in_ready(link.rx_ready),
    .in_data(rx_in),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data(rx_out)
  );

  // a register read waits while its previous answer is still unsent
  assign rx_out_ready = !(rx_out.kind == CDD_RX_REGRD && cpl_pend);
  assign pop = rx_out_valid && rx_out_ready;
  assign blk = rx_out.addr[`CDD_REG_IDX_W+1:`CDD_CHAN_IDX_W+2];
  assign idx = rx_out.addr[`CDD_CHAN_IDX_W+1:2];
  assign rd_prog_we = pop && rx_out.kind == CDD_RX_REGWR
    && blk == `CDD_RD_BLOCK;
  assign wr_prog_we = pop && rx_out.kind == CDD_RX_REGWR
    && blk == `CDD_WR_BLOCK;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpl_pend <= 1'b0;
      cpl_data <= `CDD_REG_RST;
      cpl_tag <= '0;
    end else if (pop && rx_out.kind == CDD_RX_REGRD) begin
      cpl_pend <= 1'b1;
      cpl_tag <= rx_out.tag;
      // unmapped offsets read as zero
      if (blk == `CDD_RD_BLOCK) begin
        cpl_data <= rd_prdata;
      end else if (blk == `CDD_WR_BLOCK) begin
        cpl_data <= wr_prdata;
      end else begin
        cpl_data <= `CDD_REG_RST;
      end
    end else if (g_cpl) begin
      cpl_pend <= 1'b0;
    end
  end

  // ********************
  // channels
  // ********************
  cdd_chan #(.IS_READ(1'b1), .TAG_DESC(`CDD_TAG_RD_DESC),
    .TAG_DATA(`CDD_TAG_RD_DATA), .MEM_AW(MEM_AW)) u_rd (
    .clk(clk), .rst(rst), .prog_we(rd_prog_we), .prog_idx(idx),
    .prog_wdata(rx_out.data), .prog_rdata(rd_prdata), .busy(rd_busy),
    .req_valid(rd_req), .req_kind(rd_kind), .req_addr(rd_addr),
    .req_len(rd_len), .req_tag(rd_tag), .req_data(rd_data), .grant(g_rd),
    .cpl_valid(pop && rx_out.kind == CDD_RX_CPL), .cpl_tag(rx_out.tag),
    .cpl_data(rx_out.data), .mem_we(rd_mem_we), .mem_addr(rd_mem_addr),
    .mem_wdata(rd_mem_wdata), .mem_rdata(`CDD_REG_RST), .msi_req(rd_msi),
    .msi_ack(link.msi_ready && rd_msi)
  );

  cdd_chan #(.IS_READ(1'b0), .TAG_DESC(`CDD_TAG_WR_DESC),
    .TAG_DATA(`CDD_TAG_WR_DATA), .MEM_AW(MEM_AW)) u_wr (
    .clk(clk), .rst(rst), .prog_we(wr_prog_we), .prog_idx(idx),
    .prog_wdata(rx_out.data), .prog_rdata(wr_prdata), .busy(wr_busy),
    .req_valid(wr_req), .req_kind(wr_kind), .req_addr(wr_addr),
    .req_len(wr_len), .req_tag(wr_tag), .req_data(wr_data), .grant(g_wr),
    .cpl_valid(pop && rx_out.kind == CDD_RX_CPL), .cpl_tag(rx_out.tag),
    .cpl_data(rx_out.data), .mem_we(), .mem_addr(wr_mem_addr),
    .mem_wdata(), .mem_rdata(mem[wr_mem_addr]), .msi_req(wr_msi),
    .msi_ack(link.msi_ready && wr_msi && !rd_msi)
  );

  // ********************
  // local memory
  // ********************
  // a user write in the cycle the read channel stores a word is dropped
  always_ff @(posedge clk) begin
    if (rd_mem_we) begin
      mem[rd_mem_addr] <= rd_mem_wdata;
    end else if (usr_we) begin
      mem[usr_addr] <= usr_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      usr_rdata <= `CDD_REG_RST;
    end else begin
      usr_rdata <= mem[usr_addr];
    end
  end

  // ********************
  // transmit arbiter
  // ********************
  // register answers first, then the channels take turns
  assign free = !link.tx_valid || link.tx_ready;
  assign g_cpl = free && cpl_pend;
  assign g_rd = free && !cpl_pend && rd_req && (!wr_req || last_wr);
  assign g_wr = free && !cpl_pend && wr_req && !g_rd;

  // packets carry no digest: nothing to forward or check
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.tx_valid <= 1'b0;
      link.tx_kind <= CDD_TX_MRD;
      link.tx_tag <= '0;
      link.tx_addr <= `CDD_REG_RST;
      link.tx_len <= 16'h0;
      link.tx_data <= `CDD_REG_RST;
      last_wr <= 1'b0;
    end else if (free) begin
      link.tx_valid <= g_cpl || g_rd || g_wr;
      if (g_cpl) begin
        link.tx_kind <= CDD_TX_CPL;
        link.tx_tag <= cpl_tag;
        link.tx_len <= 16'h1;
        link.tx_data <= cpl_data;
      end else if (g_rd) begin
        link.tx_kind <= rd_kind;
        link.tx_tag <= rd_tag;
        link.tx_addr <= rd_addr;
        link.tx_len <= rd_len;
        link.tx_data <= rd_data;
        last_wr <= 1'b0;
      end else if (g_wr) begin
        link.tx_kind <= wr_kind;
        link.tx_tag <= wr_tag;
        link.tx_addr <= wr_addr;
        link.tx_len <= wr_len;
        link.tx_data <= wr_data;
        last_wr <= 1'b1;
      end
    end
  end

  assign link.msi_valid = rd_msi || wr_msi;
  assign link.msi_vec = rd_msi ? `CDD_MSI_VEC_RD : `CDD_MSI_VEC_WR;
endmodule // cdd_dev

/* logic/cdd_host.sv */
// Purpose: host end: shared memory, completer and register programmer
// Assumes: one read request served at a time, completions in order
// Notes: user builds descriptor tables through the memory port
`timescale 1ns/10ps
`include "cdd_cfg.svh"
module cdd_host #(
  parameter int MEM_AW = 12
) (
  input wire logic clk,
  input wire logic rst,
  cdd_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [`CDD_REG_IDX_W-1:0] cmd_idx,
  input wire logic [`CDD_DW-1:0] cmd_data,
  output logic resp_valid,
  output logic [`CDD_DW-1:0] resp_data,
  input wire logic [MEM_AW-1:0] mem_addr,
  input wire logic mem_we,
  input wire logic [`CDD_DW-1:0] mem_wdata,
  output logic [`CDD_DW-1:0] mem_rdata,
  output logic msi_seen,
  output logic msi_vec_seen
);
  import cdd_pkg::*;
  logic [`CDD_DW-1:0] mem [0:(1<<MEM_AW)-1];
  logic take;
  logic rx_free;
  logic cpl_busy;
  logic [MEM_AW-1:0] cpl_addr;
  logic [`CDD_LEN_W-1:0] cpl_left;
  logic [`CDD_TAG_W-1:0] cpl_tag;

  // one request in service at a time: reads stall the transmit side
  assign link.tx_ready = !cpl_busy;
  assign take = link.tx_valid && !cpl_busy;
  assign rx_free = !link.rx_valid || link.rx_ready;
  assign cmd_ready = rx_free && !cpl_busy;
  assign link.msi_ready = 1'b1;

  // ********************
  // shared memory
  // ********************
  // tables must be written here before a chain is started
  always_ff @(posedge clk) begin
    if (take && link.tx_kind == CDD_TX_MWR) begin
      mem[link.tx_addr[MEM_AW+1:2]] <= link.tx_data;
    end else if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_rdata <= `CDD_REG_RST;
      resp_valid <= 1'b0;
      resp_data <= `CDD_REG_RST;
      msi_seen <= 1'b0;
      msi_vec_seen <= 1'b0;
    end else begin
      mem_rdata <= mem[mem_addr];
      resp_valid <= take && link.tx_kind == CDD_TX_CPL;
      if (take && link.tx_kind == CDD_TX_CPL) begin
        resp_data <= link.tx_data;
      end
      msi_seen <= link.msi_valid;
      if (link.msi_valid) begin
        msi_vec_seen <= link.msi_vec;
      end
    end
  end

  // ********************
  // completion generator
  // ********************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpl_busy <= 1'b0;
      cpl_addr <= '0;
      cpl_left <= 16'h0;
      cpl_tag <= '0;
    end else if (take && link.tx_kind == CDD_TX_MRD) begin
      cpl_busy <= 1'b1;
      cpl_addr <= link.tx_addr[MEM_AW+1:2];
      cpl_left <= link.tx_len;
      cpl_tag <= link.tx_tag;
    end else if (cpl_busy && rx_free) begin
      cpl_addr <= cpl_addr + 1'b1;
      cpl_left <= cpl_left - 16'h1;
      if (cpl_left == 16'h1) begin
        cpl_busy <= 1'b0;
      end
    end
  end

  // ********************
  // receive-side driver
  // ********************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.rx_valid <= 1'b0;
      link.rx_kind <= CDD_RX_CPL;
      link.rx_tag <= '0;
      link.rx_addr <= `CDD_REG_RST;
      link.rx_data <= `CDD_REG_RST;
    end else if (rx_free) begin
      if (cpl_busy) begin
        link.rx_valid <= 1'b1;
        link.rx_kind <= CDD_RX_CPL;
        link.rx_tag <= cpl_tag;
        link.rx_data <= mem[cpl_addr];
      end else if (cmd_valid) begin
        link.rx_valid <= 1'b1;
        link.rx_kind <= cmd_write ? CDD_RX_REGWR : CDD_RX_REGRD;
        link.rx_tag <= '0;
        link.rx_addr <= {{(`CDD_DW-`CDD_REG_IDX_W-2){1'b0}}, cmd_idx,
          2'b00};
        link.rx_data <= cmd_data;
      end else begin
        link.rx_valid <= 1'b0;
      end
    end
  end
endmodule // cdd_host

/* test/cdd_link_monitor.sv */
// Purpose: checker on the link between the DMA endpoint and host end
// Assumes: one clock domain, rst asynchronous and active high
// Notes: watches the interface signals only
`timescale 1ns/10ps
`include "cdd_cfg.svh"
module cdd_link_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire cdd_pkg::cdd_tx_kind_t tx_kind,
  input wire logic [`CDD_TAG_W-1:0] tx_tag,
  input wire logic [`CDD_DW-1:0] tx_addr,
  input wire logic [`CDD_LEN_W-1:0] tx_len,
  input wire logic [`CDD_DW-1:0] tx_data,
  input wire logic rx_valid,
  input wire cdd_pkg::cdd_rx_kind_t rx_kind,
  input wire logic [`CDD_TAG_W-1:0] rx_tag
);
  import cdd_pkg::*;
  // ********************
  // link properties
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_mrd_take;
    tx_valid && tx_ready && tx_kind == CDD_TX_MRD;
  endsequence
  sequence s_cpl_beat;
    rx_valid && rx_kind == CDD_RX_CPL && rx_tag == $past(tx_tag, 2);
  endsequence
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid &&
      $stable({tx_kind, tx_tag, tx_addr, tx_len, tx_data});
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx moved");
  property p_desc_len;
    tx_valid && tx_kind == CDD_TX_MRD && !tx_tag[1] |->
      tx_len == `CDD_DESC_DWORDS;
  endproperty
  a_desc_len: assert property (p_desc_len) else $error("desc len");
  property p_align;
    tx_valid |-> tx_addr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align) else $error("unaligned");
  property p_mwr;
    tx_valid && tx_kind == CDD_TX_MWR |->
      tx_len == 16'h0001 && tx_tag == `CDD_TAG_WR_DATA;
  endproperty
  a_mwr: assert property (p_mwr) else $error("bad write");
  property p_rd_len;
    tx_valid && tx_kind == CDD_TX_MRD && tx_tag == `CDD_TAG_RD_DATA |->
      tx_len != 16'h0000;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("zero read");
  property p_cpl;
    // first beat is loaded one edge after the take, so seen one later
    s_mrd_take |=> ##1 s_cpl_beat;
  endproperty
  a_cpl: assert property (p_cpl) else $error("no completion");
  property p_refuse;
    s_mrd_take |=> !tx_ready [*1];
  endproperty
  a_refuse: assert property (p_refuse) else $error("ready high");
  property p_cpl_one;
    tx_valid && tx_kind == CDD_TX_CPL |-> tx_len == 16'h0001;
  endproperty
  a_cpl_one: assert property (p_cpl_one) else $error("cpl len");
endmodule // cdd_link_monitor

/* test/tb.sv */
// Purpose: runs both DMA channels end to end through the host end
// Assumes: 10 MHz clock, reset held 8 cycles
// Notes: both chains are started before either ends
`timescale 1ns/10ps
module tb;
  import cdd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] usr_addr = 10'h0;
  logic usr_we = 1'b0;
  logic [31:0] usr_wdata = 32'h0;
  logic [31:0] usr_rdata, resp_data, mem_rdata, r, h, u;
  logic rd_busy, wr_busy, cmd_ready, resp_valid, msi_seen, msi_vec_seen;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [5:0] cmd_idx = 6'h0;
  logic [31:0] cmd_data = 32'h0;
  logic [11:0] mem_addr = 12'h0;
  logic mem_we = 1'b0;
  logic [31:0] mem_wdata = 32'h0;
  int num_errors = 0;
  int total_checks = 0;
  int msi_cnt = 0;
  cdd_link_if link();
  cdd_dev i_cdd_dev (.clk, .rst, .link, .usr_addr, .usr_we, .usr_wdata,
    .usr_rdata, .rd_busy, .wr_busy);
  cdd_host i_cdd_host (.clk, .rst, .link, .cmd_valid, .cmd_ready,
    .cmd_write, .cmd_idx, .cmd_data, .resp_valid, .resp_data, .mem_addr,
    .mem_we, .mem_wdata, .mem_rdata, .msi_seen, .msi_vec_seen);
  cdd_link_monitor i_cdd_link_monitor (.clk, .rst,
    .tx_valid(link.tx_valid), .tx_ready(link.tx_ready),
    .tx_kind(link.tx_kind), .tx_tag(link.tx_tag), .tx_addr(link.tx_addr),
    .tx_len(link.tx_len), .tx_data(link.tx_data),
    .rx_valid(link.rx_valid), .rx_kind(link.rx_kind),
    .rx_tag(link.rx_tag));
  initial begin
    forever #50 clk = ~clk;
  end
  // counts interrupt beats seen by the host end
  always @(posedge clk) begin
    if (msi_seen === 1'b1) begin
      msi_cnt <= msi_cnt + 1;
    end
  end
  // ********************
  // access tasks
  // ********************
  task chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task tmo(input int i);
    if (i >= 2000) begin
      chk("wait", 32'h0, 32'h1);
      results();
    end
  endtask
  // writes the same index of host and local memory in one cycle
  task mw(input logic [11:0] a, input logic [31:0] hd, ud);
    @(posedge clk);
    mem_addr <= a;
    usr_addr <= a[9:0];
    mem_wdata <= hd;
    usr_wdata <= ud;
    mem_we <= 1'b1;
    usr_we <= 1'b1;
    @(posedge clk);
    mem_we <= 1'b0;
    usr_we <= 1'b0;
  endtask
  task rd(input logic [11:0] a, output logic [31:0] hd, ud);
    @(posedge clk);
    mem_addr <= a;
    usr_addr <= a[9:0];
    repeat (2) @(posedge clk);
    hd = mem_rdata;
    ud = usr_rdata;
  endtask
  task reg_io(input logic w, input logic [5:0] idx, input logic [31:0] d,
    output logic [31:0] q);
    int i;
    i = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_idx <= idx;
    cmd_data <= d;
    do begin @(posedge clk); i++; end while (cmd_ready !== 1'b1 && i < 2000);
    tmo(i);
    cmd_valid <= 1'b0;
    i = 0;
    while (!w && resp_valid !== 1'b1 && i < 2000) begin
      @(posedge clk);
      i++;
    end
    tmo(i);
    q = resp_data;
  endtask
  task wait_busy(input logic want);
    int i;
    i = 0;
    do begin @(posedge clk); i++; end
    while (((rd_busy | wr_busy) !== want) && i < 2000);
    tmo(i);
  endtask
  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      mw(12'h180 + 12'(k), 32'hb0 + 32'(k), 32'ha0 + 32'(k));
      mw(12'h0 + 12'(k), 32'h0, 32'ha0 + 32'(k));
    end
    mw(12'h40, 32'h0001_0002, 32'h0);
    mw(12'h41, 32'h0, 32'h0);
    mw(12'h42, 32'h400, 32'h0);
    mw(12'h44, 32'h0000_0001, 32'h0);
    mw(12'h45, 32'h8, 32'h0);
    mw(12'h46, 32'h408, 32'h0);
    mw(12'h80, 32'h0001_0002, 32'h0);
    mw(12'h81, 32'h600, 32'h0);
    mw(12'h82, 32'h40, 32'h0);
    reg_io(1'b1, 6'h06, 32'h200, r);
    reg_io(1'b1, 6'h02, 32'h100, r);
    reg_io(1'b1, 6'h00, 32'h0000_0002, r);
    reg_io(1'b1, 6'h04, 32'h0001_0001, r);
    wait_busy(1'b1);
    repeat (3) @(posedge clk);
    chk("busy", {30'h0, rd_busy, wr_busy}, 32'h3);
    wait_busy(1'b0);
    rd(12'h100, h, u);
    chk("wr_dst0", h, 32'ha0);
    rd(12'h101, h, u);
    chk("wr_dst1", h, 32'ha1);
    rd(12'h102, h, u);
    chk("wr_dst2", h, 32'ha2);
    rd(12'h10, h, u);
    chk("rd_dst0", u, 32'hb0);
    rd(12'h11, h, u);
    chk("rd_dst1", u, 32'hb1);
    chk("msi_vec", {31'h0, msi_vec_seen}, 32'h1);
    chk("msi_cnt", msi_cnt, 32'h1);
    $display("test transfers done");
    reg_io(1'b1, 6'h03, 32'hffff_ffff, r);
    reg_io(1'b0, 6'h03, 32'h0, r);
    chk("wr_status", r, 32'h0000_0002);
    reg_io(1'b0, 6'h07, 32'h0, r);
    chk("rd_status", r, 32'h0000_0001);
    reg_io(1'b0, 6'h02, 32'h0, r);
    chk("wr_table", r, 32'h100);
    reg_io(1'b0, 6'h20, 32'h0, r);
    chk("unmapped", r, 32'h0);
    $display("test registers done");
    results();
  end
endmodule // tb
